// ### include/charger_pkg.sv
// Purpose: shared constants of the charger serial port and supervision
// Assumes: byte-wide register offsets, 25 MHz core clock
// Notes: long timer counts become module parameters derived from these
package charger_pkg;
  // bus address of the target
  localparam logic [6:0] TARGET_ADDR = 7'h6b;
  // register byte offsets, two-byte registers low byte first
  localparam logic [7:0] CHARGE_VOLTAGE_LIMIT_OFS = 8'h00;
  localparam logic [7:0] CHARGE_CURRENT_LIMIT_OFS = 8'h02;
  localparam logic [7:0] INPUT_CURRENT_LIMIT_OFS = 8'h06;
  localparam logic [7:0] INPUT_VOLTAGE_LIMIT_OFS = 8'h08;
  localparam logic [7:0] REVERSE_INPUT_CURRENT_LIMIT_OFS = 8'h0a;
  localparam logic [7:0] REVERSE_INPUT_VOLTAGE_LIMIT_OFS = 8'h0c;
  localparam logic [7:0] PRECHARGE_CURRENT_LIMIT_OFS = 8'h10;
  localparam logic [7:0] TERMINATION_CURRENT_LIMIT_OFS = 8'h12;
  localparam logic [7:0] PRECHARGE_TERMINATION_CONTROL_OFS = 8'h14;
  localparam logic [7:0] TIMER_CONTROL_OFS = 8'h15;
  localparam logic [7:0] THREE_STAGE_CHARGE_CONTROL_OFS = 8'h16;
  localparam logic [7:0] TIMER_STATUS_OFS = 8'h20;
  localparam logic [7:0] TIMER_FLAG_OFS = 8'h21;
  localparam logic [7:0] TIMER_MASK_OFS = 8'h22;
  // bytes held in the storage array, offsets 0x00 to 0x16
  localparam int MAP_BYTES = 23;
  // timer_control fields
  localparam int TC_RESET_BIT = 7;
  localparam int TC_WD_SEL_LSB = 4;
  localparam int TC_RESTART_BIT = 3;
  // reset values and read filler
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam logic [7:0] TIMER_CONTROL_RESET = 8'h10;
  localparam logic [7:0] READ_UNDEFINED = 8'hff;
  // timing
  localparam longint CLOCK_HZ = 64'd25000000;
  localparam longint BUS_TIMEOUT_S = 64'd2;
  localparam longint WD_SHORT_S = 64'd40;
  localparam longint WD_MID_S = 64'd80;
  localparam longint WD_LONG_S = 64'd160;
  localparam longint PRECHARGE_TIMER_H = 64'd2;
  localparam longint FASTCHARGE_TIMER_H = 64'd12;
  localparam longint SECONDS_PER_HOUR = 64'd3600;
  localparam longint ALERT_NS = 64'd1000;
  localparam int ALERT_CYC = int'((ALERT_NS * CLOCK_HZ + 64'd999999999) /
    64'd1000000000);
  localparam int COUNT_W = 44;
endpackage

// ### include/charger_i2c_if.sv
// Purpose: open-drain two-wire link between controller and target
// Assumes: both lines pulled up when nobody drives
// Notes: enables are low while an end drives its line
`timescale 1ns/1ns
`default_nettype none
interface charger_i2c_if;
  logic ctl_scl_o;
  logic ctl_scl_oe_n;
  logic ctl_sda_o;
  logic ctl_sda_oe_n;
  logic tgt_sda_o;
  logic tgt_sda_oe_n;
  logic scl;
  logic sda;
  // wired-and of the open-drain drivers
  assign scl = ctl_scl_oe_n | ctl_scl_o;
  assign sda = (ctl_sda_oe_n | ctl_sda_o) & (tgt_sda_oe_n | tgt_sda_o);
  modport target (input scl, input sda, output tgt_sda_o,
    output tgt_sda_oe_n);
  modport controller (input scl, input sda, output ctl_scl_o,
    output ctl_scl_oe_n, output ctl_sda_o, output ctl_sda_oe_n);
endinterface
`default_nettype wire

// ### src/charger_target.sv
// Purpose: charger serial target port with watchdog and safety timers
// Assumes: controller makes every clock pulse, no clock stretching
// Notes: both lines are sampled through two flip-flops before use
// Contract
// RQ1: target acknowledges each byte in ninth pulse
// RQ2: controller clocks all pulses, releases data at ack
// RQ3: data high at ninth pulse means not-acknowledge
// RQ4: seven address bits then direction, one is read
// RQ5: answer address 0x6b only, ignore others
// RQ6: undefined register address gets nack, back idle
// RQ7: multi-byte reads and writes to every register
// RQ8: pointer advances by one after each byte
// RQ9: power-on starts default mode, watchdog expired
// RQ10: default mode sets status, flag, alert unless masked
// RQ11: watchdog flag clears after being read
// RQ12: host mode holds watchdog status low
// RQ13: default mode runs 2h and 12h safety timers
// RQ14: any write enters host mode, starts watchdog
// RQ15: host restarts watchdog or disables it with 00
// RQ16: expiry returns default mode, restores registers, alerts
// RQ17: after expiry any write restarts the watchdog
// RQ18: register reset bit restores defaults, self-clears
// RQ19: host leaves unmapped offsets untouched
// RQ20: unmapped register reads return 0xff
// RQ21: two-byte registers low byte at lower address
// RQ22: start without stop over 2 s resets port
`timescale 1ns/1ns
`default_nettype none
module charger_target
  import charger_pkg::*;
#(
  parameter logic [COUNT_W-1:0] BUS_TIMEOUT_CYC =
    COUNT_W'(BUS_TIMEOUT_S * CLOCK_HZ),
  parameter logic [COUNT_W-1:0] WD_SHORT_CYC = COUNT_W'(WD_SHORT_S * CLOCK_HZ),
  parameter logic [COUNT_W-1:0] WD_MID_CYC = COUNT_W'(WD_MID_S * CLOCK_HZ),
  parameter logic [COUNT_W-1:0] WD_LONG_CYC = COUNT_W'(WD_LONG_S * CLOCK_HZ),
  parameter logic [COUNT_W-1:0] PRECHARGE_CYC =
    COUNT_W'(PRECHARGE_TIMER_H * SECONDS_PER_HOUR * CLOCK_HZ),
  parameter logic [COUNT_W-1:0] FASTCHARGE_CYC =
    COUNT_W'(FASTCHARGE_TIMER_H * SECONDS_PER_HOUR * CLOCK_HZ)
)
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // link
  charger_i2c_if.target link,
  // charger core
  input wire logic i_precharge_phase,
  input wire logic i_termination_done,
  output logic o_charge_enable,
  output logic o_host_mode,
  output logic o_alert_n
);
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_ADDR = 8'h02, ST_ACK_A = 8'h04, ST_REG = 8'h08,
    ST_ACK_R = 8'h10, ST_WDATA = 8'h20, ST_RDATA = 8'h40, ST_RACK = 8'h80
  } bus_state_e;

  logic scl_meta, scl_s, scl_d, sda_meta, sda_s, sda_d;
  logic scl_rise, scl_fall, start_seen, stop_seen, tmo_hit;
  bus_state_e state, next_state;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg, ptr, next_ptr;
  logic rw, next_rw, sda_low, next_sda_low, busy, next_busy;
  logic [COUNT_W-1:0] tmo_cnt, next_tmo_cnt;
  logic wr_en, rd_take;
  logic [7:0] rd_value;
  logic [7:0] mem [MAP_BYTES];
  logic [7:0] next_mem [MAP_BYTES];
  logic mask, next_mask, flag, next_flag, host, next_host;
  logic stop_chg, next_stop_chg, phase_d;
  logic [COUNT_W-1:0] wd_cnt, next_wd_cnt, safe_cnt, next_safe_cnt, wd_lim;
  logic [15:0] alert_cnt, next_alert_cnt;
  logic [1:0] wd_sel;

  // offsets that exist in the map
  function automatic logic is_defined(input logic [7:0] a);
    is_defined = (a <= 8'h03) || (a >= 8'h06 && a <= 8'h0d) ||
      (a >= 8'h10 && a <= 8'h16) || (a >= TIMER_STATUS_OFS &&
      a <= TIMER_MASK_OFS);
  endfunction

  // two-stage synchronisers plus one history stage for edges
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      {scl_meta, scl_s, scl_d} <= 3'h7;
      {sda_meta, sda_s, sda_d} <= 3'h7;
    end
    else
    begin
      {scl_meta, scl_s, scl_d} <= {link.scl, scl_meta, scl_s};
      {sda_meta, sda_s, sda_d} <= {link.sda, sda_meta, sda_s};
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_seen = scl_s & scl_d & ~sda_d & sda_s;
  assign tmo_hit = busy && (tmo_cnt >= BUS_TIMEOUT_CYC - 1'b1); // see RQ22

  // read mux; unmapped offsets give the filler byte
  always_comb
  begin
    if (ptr == TIMER_STATUS_OFS)
      rd_value = {7'h00, ~host}; // see RQ12
    else if (ptr == TIMER_FLAG_OFS)
      rd_value = {7'h00, flag};
    else if (ptr == TIMER_MASK_OFS)
      rd_value = {7'h00, mask};
    else if (is_defined(ptr))
      rd_value = mem[ptr[4:0]]; // see RQ21
    else
      rd_value = READ_UNDEFINED; // see RQ20
  end

  // bus state machine next values
  always_comb
  begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_ptr = ptr;
    next_rw = rw;
    next_sda_low = sda_low;
    next_busy = busy;
    next_tmo_cnt = busy ? tmo_cnt + 1'b1 : '0;
    wr_en = 1'b0;
    rd_take = 1'b0;
    if (start_seen)
    begin
      next_state = ST_ADDR;
      next_bitcnt = 4'h0;
      next_sda_low = 1'b0;
      next_busy = 1'b1;
      next_tmo_cnt = '0;
    end
    else if (stop_seen || tmo_hit)
    begin
      next_state = ST_IDLE; // see RQ22
      next_sda_low = 1'b0;
      next_busy = 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
          next_sda_low = 1'b0;
        ST_ADDR, ST_REG, ST_WDATA:
        begin
          if (scl_rise)
          begin
            next_shreg = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 1'b1;
          end
          else if (scl_fall && bitcnt == 4'h8)
          begin
            next_bitcnt = 4'h0;
            next_sda_low = 1'b1; // see RQ1
            next_state = ST_ACK_R;
            if (state == ST_ADDR)
            begin
              next_rw = shreg[0]; // see RQ4
              next_state = ST_ACK_A;
              if (shreg[7:1] != TARGET_ADDR)
              begin
                next_sda_low = 1'b0; // see RQ5
                next_state = ST_IDLE;
              end
            end
            else if (state == ST_REG)
            begin
              next_ptr = shreg;
              if (!is_defined(shreg))
              begin
                next_sda_low = 1'b0; // see RQ6
                next_state = ST_IDLE;
              end
            end
            else
            begin
              wr_en = 1'b1; // see RQ7
              next_ptr = ptr + 1'b1; // see RQ8
            end
          end
        end
        ST_ACK_A:
          if (scl_fall)
          begin
            if (rw)
            begin
              rd_take = 1'b1;
              next_sda_low = ~rd_value[7];
              next_shreg = {rd_value[6:0], 1'b0};
              next_bitcnt = 4'h1;
              next_state = ST_RDATA;
            end
            else
            begin
              next_sda_low = 1'b0;
              next_state = ST_REG;
            end
          end
        ST_ACK_R:
          if (scl_fall)
          begin
            next_sda_low = 1'b0;
            next_state = ST_WDATA;
          end
        ST_RDATA:
          if (scl_fall)
          begin
            if (bitcnt == 4'h8)
            begin
              next_sda_low = 1'b0;
              next_bitcnt = 4'h0;
              next_state = ST_RACK;
            end
            else
            begin
              next_sda_low = ~shreg[7];
              next_shreg = {shreg[6:0], 1'b0};
              next_bitcnt = bitcnt + 1'b1;
            end
          end
        ST_RACK:
          if (scl_rise)
          begin
            if (sda_s)
              next_state = ST_IDLE; // see RQ3
            else
              next_ptr = ptr + 1'b1; // see RQ8
          end
          else if (scl_fall)
          begin
            rd_take = 1'b1;
            next_sda_low = ~rd_value[7];
            next_shreg = {rd_value[6:0], 1'b0};
            next_bitcnt = 4'h1;
            next_state = ST_RDATA;
          end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      sda_low <= 1'b0;
      busy <= 1'b0;
      tmo_cnt <= '0;
    end
    else
    begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      ptr <= next_ptr;
      rw <= next_rw;
      sda_low <= next_sda_low;
      busy <= next_busy;
      tmo_cnt <= next_tmo_cnt;
    end
  end

  assign wd_sel = mem[TIMER_CONTROL_OFS[4:0]][TC_WD_SEL_LSB +: 2];
  assign wd_lim = (wd_sel == 2'h1) ? WD_SHORT_CYC :
    (wd_sel == 2'h2) ? WD_MID_CYC : WD_LONG_CYC;

  // register file, mode and timer next values
  always_comb
  begin
    logic expire, restore;
    expire = host && (wd_sel != 2'h0) && (wd_cnt >= wd_lim - 1'b1);
    restore = 1'b0;
    next_mem = mem;
    next_mask = mask;
    next_host = host;
    next_flag = (rd_take && ptr == TIMER_FLAG_OFS) ? 1'b0 : flag; // see RQ11
    next_alert_cnt = (alert_cnt != 16'h0) ? alert_cnt - 1'b1 : alert_cnt;
    next_wd_cnt = (host && wd_sel != 2'h0) ? wd_cnt + 1'b1 : '0; // see RQ15
    if (wr_en)
    begin
      next_host = 1'b1; // see RQ14
      next_wd_cnt = '0; // see RQ17
      if (ptr == TIMER_MASK_OFS)
        next_mask = shreg[0];
      else if (ptr == TIMER_CONTROL_OFS)
      begin
        next_mem[ptr[4:0]] = shreg & ~(8'h01 << TC_RESET_BIT) &
          ~(8'h01 << TC_RESTART_BIT); // see RQ18
        restore = shreg[TC_RESET_BIT];
      end
      else if (ptr < 8'(MAP_BYTES) && is_defined(ptr))
        next_mem[ptr[4:0]] = shreg;
    end
    else if (expire)
    begin
      next_host = 1'b0; // see RQ16
      restore = 1'b1;
      next_flag = 1'b1; // see RQ10
      if (!mask)
        next_alert_cnt = 16'(ALERT_CYC);
    end
    if (restore)
    begin
      for (int i = 0; i < MAP_BYTES; i++)
        next_mem[i] = (i == int'(TIMER_CONTROL_OFS)) ? TIMER_CONTROL_RESET :
          REG_RESET_VALUE;
      next_wd_cnt = '0;
    end
    // safety timers only run in default mode, restarted per phase
    next_safe_cnt = (host || restore || i_precharge_phase != phase_d) ? '0 :
      safe_cnt + 1'b1; // see RQ13
    next_stop_chg = host ? 1'b0 : stop_chg;
    if (!host && !i_termination_done && safe_cnt >=
      (phase_d ? PRECHARGE_CYC : FASTCHARGE_CYC) - 1'b1)
      next_stop_chg = 1'b1; // see RQ13
  end

  // power-on leaves default mode with flag set and alert pulsing
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < MAP_BYTES; i++)
        mem[i] <= (i == int'(TIMER_CONTROL_OFS)) ? TIMER_CONTROL_RESET :
          REG_RESET_VALUE;
      mask <= 1'b0;
      flag <= 1'b1; // see RQ9
      host <= 1'b0;
      wd_cnt <= '0;
      safe_cnt <= '0;
      stop_chg <= 1'b0;
      phase_d <= 1'b1;
      alert_cnt <= 16'(ALERT_CYC);
    end
    else
    begin
      mem <= next_mem;
      mask <= next_mask;
      flag <= next_flag;
      host <= next_host;
      wd_cnt <= next_wd_cnt;
      safe_cnt <= next_safe_cnt;
      stop_chg <= next_stop_chg;
      phase_d <= i_precharge_phase;
      alert_cnt <= next_alert_cnt;
    end
  end

  // open drain: only ever pulls low
  assign link.tgt_sda_o = 1'b0;
  assign link.tgt_sda_oe_n = ~sda_low;
  assign o_charge_enable = ~stop_chg;
  assign o_host_mode = host;
  assign o_alert_n = (alert_cnt == 16'h0);
endmodule
`default_nettype wire

// ### src/charger_controller.sv
// Purpose: bus controller end that reads and writes charger registers
// Assumes: target never stretches the clock
// Notes: data changes one quarter after the clock falls to avoid
//   false start or stop at the target's synchronisers
`timescale 1ns/1ns
`default_nettype none
module charger_controller
  import charger_pkg::*;
#(
  parameter int QUARTER_CYC = 4
)
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // link
  charger_i2c_if.controller link,
  // command
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic i_cmd_read,
  input wire logic [6:0] i_cmd_dev,
  input wire logic [7:0] i_cmd_reg,
  input wire logic [7:0] i_cmd_count,
  // data
  input wire logic [7:0] i_wdata,
  output logic o_wdata_take,
  output logic [7:0] o_rdata,
  output logic o_rdata_valid,
  output logic o_done,
  output logic o_nack
);
  typedef enum logic [4:0] {
    C_IDLE = 5'h01, C_START = 5'h02, C_SEND = 5'h04, C_RECV = 5'h08,
    C_STOP = 5'h10
  } ctl_state_e;

  ctl_state_e st, next_st;
  logic [7:0] qcnt, next_qcnt, tx, next_tx, rx, next_rx, rem, next_rem;
  logic [7:0] rdata, next_rdata, regad, next_regad;
  logic [6:0] dev, next_dev;
  logic [1:0] q, next_q, stage, next_stage;
  logic [3:0] bitn, next_bitn;
  logic scl, next_scl, sda, next_sda, rd, next_rd, nack, next_nack;
  logic rvalid, next_rvalid, done, next_done, take, next_take;
  logic sda_meta, sda_s, tick;

  // data line from the pin through two flip-flops
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      {sda_meta, sda_s} <= 2'h3;
    else
      {sda_meta, sda_s} <= {link.sda, sda_meta};
  end

  assign tick = (st != C_IDLE) && (qcnt == 8'(QUARTER_CYC - 1));

  always_comb
  begin
    next_st = st;
    next_qcnt = (st == C_IDLE || tick) ? 8'h00 : qcnt + 1'b1;
    next_q = tick ? q + 1'b1 : q;
    {next_tx, next_rx, next_rem, next_rdata} = {tx, rx, rem, rdata};
    {next_dev, next_regad, next_stage, next_bitn} = {dev, regad, stage, bitn};
    {next_scl, next_sda, next_rd, next_nack} = {scl, sda, rd, nack};
    {next_rvalid, next_done, next_take} = 3'h0;
    if (st == C_IDLE)
    begin
      if (i_cmd_valid)
      begin
        {next_dev, next_regad, next_rem, next_rd} =
          {i_cmd_dev, i_cmd_reg, i_cmd_count, i_cmd_read};
        next_tx = {i_cmd_dev, 1'b0};
        {next_stage, next_nack, next_q} = {2'h0, 1'b0, 2'h0};
        next_scl = 1'b0;
        next_st = C_START;
      end
    end
    else if (tick && q != 2'h3)
    begin
      // quarter 0 sets data, quarter 1 raises the clock
      if (q == 2'h1)
        next_scl = 1'b1;
      else if (st == C_START)
        next_sda = 1'b1;
      else if (st == C_STOP)
        next_sda = 1'b0;
      else if (st == C_SEND)
        next_sda = (bitn == 4'h8) ? 1'b1 : tx[7]; // see RQ2
      else
        next_sda = (bitn == 4'h8) ? (rem == 8'h01) : 1'b1; // see RQ3
      if (q == 2'h2 && st == C_START)
        next_sda = 1'b0;
      if (q == 2'h2 && st == C_STOP)
        next_sda = 1'b1;
    end
    else if (tick)
    begin
      // end of the high phase: sample, then next bit with clock low
      next_scl = 1'b0;
      next_bitn = bitn + 1'b1;
      unique case (st)
        C_START:
        begin
          next_bitn = 4'h0;
          next_st = C_SEND;
        end
        C_STOP:
        begin
          next_done = 1'b1;
          next_scl = 1'b1;
          next_st = C_IDLE;
        end
        C_SEND:
          if (bitn != 4'h8)
            next_tx = {tx[6:0], 1'b0};
          else
          begin
            next_bitn = 4'h0;
            if (sda_s)
            begin
              next_nack = 1'b1;
              next_st = C_STOP;
            end
            else if (stage == 2'h0)
            begin
              {next_tx, next_stage} = {regad, 2'h1};
            end
            else if (stage == 2'h3)
              next_st = C_RECV;
            else if (stage == 2'h1 && rd)
            begin
              {next_tx, next_stage} = {dev, 1'b1, 2'h3};
              next_st = C_START;
            end
            else
            begin
              next_rem = (stage == 2'h2) ? rem - 1'b1 : rem;
              next_stage = 2'h2;
              if (next_rem == 8'h00)
                next_st = C_STOP;
              else
                {next_tx, next_take} = {i_wdata, 1'b1};
            end
          end
        C_RECV:
          if (bitn != 4'h8)
            next_rx = {rx[6:0], sda_s};
          else
          begin
            next_bitn = 4'h0;
            {next_rdata, next_rvalid} = {rx, 1'b1};
            next_rem = rem - 1'b1;
            if (rem <= 8'h01)
              next_st = C_STOP;
          end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st <= C_IDLE;
      {qcnt, tx, rx, rem, rdata, regad} <= '0;
      {dev, q, stage, bitn} <= '0;
      {scl, sda, rd, nack} <= 4'hc;
      {rvalid, done, take} <= 3'h0;
    end
    else
    begin
      st <= next_st;
      {qcnt, tx, rx, rem, rdata, regad} <=
        {next_qcnt, next_tx, next_rx, next_rem, next_rdata, next_regad};
      {dev, q, stage, bitn} <= {next_dev, next_q, next_stage, next_bitn};
      {scl, sda, rd, nack} <= {next_scl, next_sda, next_rd, next_nack};
      {rvalid, done, take} <= {next_rvalid, next_done, next_take};
    end
  end

  assign link.ctl_scl_o = 1'b0;
  assign link.ctl_scl_oe_n = scl;
  assign link.ctl_sda_o = 1'b0;
  assign link.ctl_sda_oe_n = sda;
  assign o_cmd_ready = (st == C_IDLE);
  assign o_wdata_take = take;
  assign o_rdata = rdata;
  assign o_rdata_valid = rvalid;
  assign o_done = done;
  assign o_nack = nack;
endmodule
`default_nettype wire

// ### verif/charger_link_chk.sv
// Purpose: wire checks of the charger serial link
// Assumes: open-drain ends, no clock stretching
// Notes: sees interface signals only
`timescale 1ns/1ns
`default_nettype none
module charger_link_chk (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // link wires and drivers
  input wire logic scl,
  input wire logic sda,
  input wire logic ctl_scl_o,
  input wire logic ctl_sda_o,
  input wire logic tgt_sda_o,
  input wire logic tgt_sda_oe_n
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  // start and stop while the clock stays high
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  // target moves its drive only in the low phase
  a_tgt_stable_high: assert property (
    scl && $past(scl) |-> $stable(tgt_sda_oe_n)) else $error("sda moved");
  a_tgt_drive_low: assert property (
    $fell(tgt_sda_oe_n) |-> !scl) else $error("drive in high phase");
  a_tgt_free_low: assert property (
    $rose(tgt_sda_oe_n) |-> !scl) else $error("release in high phase");
  // target stays released for 8 clock cycles from the start cycle on, and for 8 cycles after a stop
  a_start_quiet: assert property (
    s_start |-> tgt_sda_oe_n [*8]) else $error("target busy at start");
  a_stop_idle: assert property (
    s_stop |=> tgt_sda_oe_n [*8]) else $error("target busy after stop");
  // open-drain ends only ever pull low
  a_tgt_pull_only: assert property (
    !tgt_sda_o) else $error("target drives high");
  a_ctl_pull_only: assert property (
    !ctl_scl_o && !ctl_sda_o) else $error("controller drives high");
  // lines are free as reset ends
  a_reset_free: assert property (
    $rose(i_rst_n) |-> tgt_sda_oe_n && scl) else $error("line held");
endmodule
`default_nettype wire

// ### verif/charger_i2c_target_watchdog_tb_top.sv
// Purpose: end-to-end bench of charger controller and target
// Assumes: short timer parameters, bench model of the register map
// Notes: inputs change at the falling edge
`timescale 1ns/1ns
`default_nettype none
module charger_i2c_target_watchdog_tb_top;
  import charger_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_precharge_phase = 1'b1;
  logic i_termination_done = 1'b0;
  logic i_cmd_valid = 1'b0;
  logic i_cmd_read = 1'b0;
  logic [6:0] i_cmd_dev = 7'h00;
  logic [7:0] i_cmd_reg = 8'h00;
  logic [7:0] i_cmd_count = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic o_cmd_ready, o_wdata_take, o_rdata_valid, o_done, o_nack;
  logic o_charge_enable, o_host_mode, o_alert_n;
  logic [7:0] mdl [256];
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  logic [7:0] lfsr = 8'h55;
  int error_cnt = 0;
  int tests_run = 0;
  charger_i2c_if link_if ();
  // 20 ns half period gives 25 MHz
  always #20 i_clock = ~i_clock;
  // short counts keep the run small; mid and long selects never used
  charger_target #(.BUS_TIMEOUT_CYC(44'd2000), .WD_SHORT_CYC(44'd5000),
    .PRECHARGE_CYC(44'd3000), .FASTCHARGE_CYC(44'd6000))
  charger_target_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .link(link_if), .i_precharge_phase(i_precharge_phase),
    .i_termination_done(i_termination_done),
    .o_charge_enable(o_charge_enable),
    .o_host_mode(o_host_mode), .o_alert_n(o_alert_n));
  charger_controller charger_controller_inst (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .link(link_if), .i_cmd_valid(i_cmd_valid),
    .o_cmd_ready(o_cmd_ready), .i_cmd_read(i_cmd_read),
    .i_cmd_dev(i_cmd_dev), .i_cmd_reg(i_cmd_reg),
    .i_cmd_count(i_cmd_count), .i_wdata(i_wdata),
    .o_wdata_take(o_wdata_take), .o_rdata(o_rdata),
    .o_rdata_valid(o_rdata_valid), .o_done(o_done), .o_nack(o_nack));
  charger_link_chk charger_link_chk_inst (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .scl(link_if.scl), .sda(link_if.sda),
    .ctl_scl_o(link_if.ctl_scl_o), .ctl_sda_o(link_if.ctl_sda_o),
    .tgt_sda_o(link_if.tgt_sda_o), .tgt_sda_oe_n(link_if.tgt_sda_oe_n));
  // verdict and end of run
  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen,
    input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic mapped(input int a);
    return a < 4 || (a > 5 && a < 14) || (a > 15 && a < 23);
  endfunction
  // register defaults; holes read as all ones
  task automatic model_reset();
    for (int a = 0; a < 256; a++)
      mdl[a] = mapped(a) ? 8'h00 : 8'hff;
    mdl[21] = 8'h10;
  endtask
  // one controller command, bounded wait for its completion
  task automatic xfer(input logic rd, input logic [6:0] dev,
    input logic [7:0] rg, input int n);
    int w;
    int t;
    w = 0;
    rq.delete();
    i_cmd_read = rd;
    i_cmd_dev = dev;
    i_cmd_reg = rg;
    i_cmd_count = 8'(n);
    i_wdata = (wq.size() > 0) ? wq[0] : 8'h00;
    i_cmd_valid = 1'b1;
    @(negedge i_clock);
    i_cmd_valid = 1'b0;
    for (t = 0; t < 20000; t++)
    begin
      @(negedge i_clock);
      if (o_rdata_valid === 1'b1)
        rq.push_back(o_rdata);
      if (o_wdata_take === 1'b1)
        w++;
      i_wdata = (w < wq.size()) ? wq[w] : 8'h00;
      if (o_done === 1'b1)
        break;
    end
    if (t == 20000)
    begin
      error_cnt++;
      wrap_up();
    end
  endtask
  // random bytes written and mirrored into the model
  task automatic wr(input logic [7:0] rg, input int n);
    wq.delete();
    for (int k = 0; k < n; k++)
    begin
      lfsr = nxt(lfsr);
      wq.push_back(lfsr);
      if (mapped(rg + k))
        mdl[rg + k] = lfsr;
    end
    xfer(1'b0, TARGET_ADDR, rg, n);
  endtask
  task automatic rd(input logic [7:0] rg, input int n);
    xfer(1'b1, TARGET_ADDR, rg, n);
    chk("read count", 8'(rq.size()), 8'(n));
    for (int k = 0; k < rq.size(); k++)
      chk("read data", rq[k], mdl[rg + k]);
  endtask
  // a missing byte shows as unknown and so never matches
  task automatic one(input string nm, input logic [7:0] rg,
    input logic [7:0] exp);
    xfer(1'b1, TARGET_ADDR, rg, 1);
    rq.push_back(8'hxx);
    chk(nm, rq[0], exp);
  endtask
  // main sequence
  initial
  begin
    int w;
    model_reset();
    repeat (5) @(negedge i_clock);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_clock);
    chk("alert", {7'h00, o_alert_n}, 8'h00);
    one("flag", 8'h21, 8'h01);
    one("flag", 8'h21, 8'h00);
    one("status", 8'h20, 8'h01);
    chk("host", {7'h00, o_host_mode}, 8'h00);
    rd(8'h00, 4);
    repeat (1500) @(negedge i_clock);
    chk("charge", {7'h00, o_charge_enable}, 8'h00);
    wr(8'h00, 4);
    chk("host", {7'h00, o_host_mode}, 8'h01);
    chk("charge", {7'h00, o_charge_enable}, 8'h01);
    rd(8'h02, 4);
    one("status", 8'h20, 8'h00);
    xfer(1'b0, 7'h6a, 8'h00, 0);
    chk("nack", {7'h00, o_nack}, 8'h01);
    xfer(1'b1, TARGET_ADDR, 8'h04, 1);
    chk("nack", {7'h00, o_nack}, 8'h01);
    rd(8'h00, 1);
    wq = '{8'h80};
    xfer(1'b0, TARGET_ADDR, 8'h15, 1);
    model_reset();
    rd(8'h00, 2);
    one("timer control", 8'h15, 8'h10);
    wr(8'h06, 2);
    // bounded wait for the watchdog to run out
    for (w = 0; w < 5600 && o_host_mode === 1'b1; w++)
      @(negedge i_clock);
    chk("expiry late", {7'h00, w > 4800}, 8'h01);
    chk("host", {7'h00, o_host_mode}, 8'h00);
    chk("alert", {7'h00, o_alert_n}, 8'h00);
    model_reset();
    rd(8'h06, 2);
    one("flag", 8'h21, 8'h01);
    one("status", 8'h20, 8'h01);
    // termination seen: the safety timer must not stop charging
    i_termination_done = 1'b1;
    repeat (1500) @(negedge i_clock);
    chk("charge", {7'h00, o_charge_enable}, 8'h01);
    wr(8'h00, 2);
    chk("host", {7'h00, o_host_mode}, 8'h01);
    // masked expiry: flag still set, alert held off
    wq = '{8'h01};
    xfer(1'b0, TARGET_ADDR, 8'h22, 1);
    for (w = 0; w < 5600 && o_host_mode === 1'b1; w++)
      @(negedge i_clock);
    chk("masked alert", {7'h00, o_alert_n}, 8'h01);
    one("flag", 8'h21, 8'h01);
    wrap_up();
  end
endmodule
`default_nettype wire
